// file: bench/pgtm_far_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pgtm_far_monitor (
	input wire logic clk_sys, // Clock.
	input wire logic reset, // Reset.
	input wire logic pgOutputPinC, // Watched output.
	output logic [7:0] dropCount // Good-to-bad steps seen.
);
	logic lastLevel;
	// A supervisor only acts on falls; reset hides the pin from it.
	always_ff @(posedge clk_sys) begin
		lastLevel <= reset ? 1'b0 : pgOutputPinC;
		if (reset) dropCount <= 8'h00;
		else if (lastLevel && !pgOutputPinC) dropCount <= dropCount + 8'h01;
	end
endmodule
`default_nettype wire

// file: bench/pgtm_mask_out3_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pgtm_mask_out3_properties (
	input wire logic clk_sys, // Clock.
	input wire logic reset, // Reset.
	input wire logic [7:0] regAddr, // Offset.
	input wire logic [7:0] regWrData, // Write data.
	input wire logic regWrEn, // Write strobe.
	input wire logic regRdEn, // Read strobe.
	input wire logic [7:0] regRdData, // Read data.
	input wire logic regRdValid, // Read valid.
	input wire logic [5:0] stepDownPg, // Rails good.
	input wire logic [5:0] controlPin, // Pin levels.
	input wire logic pgOutputPinC // Tree result.
);
	logic [7:0] railM;
	logic [7:0] auxM;
	// Shadow masks, so the tree checks know which sources count.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			railM <= 8'h00;
			auxM <= 8'h00;
		end else if (regWrEn) begin
			if (regAddr == 8'hAA) railM <= regWrData;
			if (regAddr == 8'hAB) auxM <= regWrData;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_rdValid; regRdEn |=> regRdValid; endproperty
	property p_noValid; !regRdEn |=> !regRdValid; endproperty
	property p_railBack; regWrEn && regAddr == 8'hAA ##1 regRdEn && !regWrEn
		&& regAddr == 8'hAA |=> regRdData == $past(regWrData, 2); endproperty
	property p_auxBack; regWrEn && regAddr == 8'hAB ##1 regRdEn && !regWrEn
		&& regAddr == 8'hAB |=> regRdData == $past(regWrData, 2); endproperty
	property p_sleepRd; regRdEn && regAddr == 8'hAC |=> regRdData[7:2] == 6'h00;
	endproperty
	property p_unmapped; regRdEn && regAddr == 8'hAD |=> regRdData == 8'h00;
	endproperty
	// Four cycles cover the two synchroniser stages and the output flop.
	property p_railDrop; (!railM[0] && !stepDownPg[0]) [*4] |-> !pgOutputPinC;
	endproperty
	property p_pinDrop; (!auxM[4] && !controlPin[0]) [*4] |-> !pgOutputPinC;
	endproperty
	a_rdValid: assert property (p_rdValid) else $error("no read valid");
	a_noValid: assert property (p_noValid) else $error("stray valid");
	a_railBack: assert property (p_railBack) else $error("rails readback");
	a_auxBack: assert property (p_auxBack) else $error("aux readback");
	a_sleepRd: assert property (p_sleepRd) else $error("sleep upper bits");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_railDrop: assert property (p_railDrop) else $error("rail drop");
	a_pinDrop: assert property (p_pinDrop) else $error("pin drop");
	c_unmapped: cover property (regRdEn && regAddr == 8'hAD);
	c_fall: cover property ($fell(pgOutputPinC));
	c_masked: cover property (railM == 8'h01 && !stepDownPg[0] ##4 pgOutputPinC);
endmodule
bind pgtm_mask_out3 pgtm_mask_out3_properties chk (.clk_sys, .reset, .regAddr,
	.regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid, .stepDownPg,
	.controlPin, .pgOutputPinC);
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pgtm_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic [7:0] dropCount;
	logic regRdValid;
	logic pgOutputPinC;
	logic pgLdoPath;
	logic [17:0] good = '1;
	int mismatches = 0;
	int comparisons = 0;
	// Bit i of good is the source gated by mask bit i of AA, AB, AC in turn.
	pgtm_mask_out3 dut (.clk_sys, .reset, .regAddr, .regWrData, .regWrEn,
		.regRdEn, .regRdData, .regRdValid, .stepDownPg(good[5:0]),
		.adjLdoOnePg(1'b0), .adjLdoTwoPg(good[7]), .adjLdoThreePg(good[8]),
		.loadSwitchAOnePg(good[6]), .loadSwitchBOnePg(good[9]),
		.loadSwitchBTwoPg(good[10]), .terminationPg(good[11]), .controlPin({
		good[16:14], good[17], good[13:12]}), .pgOutputPinC);
	pgtm_far_monitor mon (.clk_sys, .reset, .pgOutputPinC, .dropCount);
	// Twin whose shared input is adjustable LDO one; switch B two held bad.
	pgtm_mask_out3 #(.SHARED_USE_LDO(1'b1)) dutLdo (.clk_sys, .reset,
		.regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData(),
		.regRdValid(), .stepDownPg(good[5:0]), .adjLdoOnePg(good[10]),
		.adjLdoTwoPg(good[7]), .adjLdoThreePg(good[8]),
		.loadSwitchAOnePg(good[6]), .loadSwitchBOnePg(good[9]),
		.loadSwitchBTwoPg(1'b0), .terminationPg(good[11]), .controlPin({
		good[16:14], good[17], good[13:12]}), .pgOutputPinC(pgLdoPath));
	task automatic check(input string nm, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk_sys);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		check("regRdValid", {7'h00, regRdValid}, 8'h01);
		check("regRdData", regRdData, exp);
	endtask
	task automatic wrrd(input logic [7:0] a, d, exp);
		@(posedge clk_sys);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		rd(a, exp);
	endtask
	task automatic setMask(input logic [17:0] m);
		wrrd(PGTM_OFS_RAILS, m[7:0], m[7:0]);
		wrrd(PGTM_OFS_PINS_AUX, m[15:8], m[15:8]);
		wrrd(PGTM_OFS_SLEEP, {6'h00, m[17:16]}, {6'h00, m[17:16]});
	endtask
	// Three edges through the synchroniser and output flop, plus margin.
	task automatic settle(input logic [7:0] exp);
		repeat (4) @(posedge clk_sys);
		#1;
		check("pgOutputPinC", {7'h00, pgOutputPinC}, exp);
		check("pgLdoPath", {7'h00, pgLdoPath}, exp);
	endtask
	task automatic t_regs();
		rd(PGTM_OFS_RAILS, PGTM_RST_RAILS);
		rd(PGTM_OFS_PINS_AUX, PGTM_RST_PINS_AUX);
		rd(PGTM_OFS_SLEEP, PGTM_RST_SLEEP);
		wrrd(PGTM_OFS_RAILS, 8'h5A, 8'h5A);
		wrrd(PGTM_OFS_PINS_AUX, 8'hA5, 8'hA5);
		wrrd(PGTM_OFS_SLEEP, 8'hFF, 8'h03);
		wrrd(8'hAD, 8'h77, PGTM_RD_UNMAPPED);
		rd(PGTM_OFS_RAILS, 8'h5A);
		setMask('0);
		$display("t_regs done");
	endtask
	task automatic t_tree();
		settle(8'h01);
		for (int i = 0; i < 18; i++) begin
			@(posedge clk_sys);
			good[i] <= 1'b0;
			settle(8'h00);
			setMask(18'h1 << i);
			settle(8'h01);
			@(posedge clk_sys);
			good[i] <= 1'b1;
			setMask('0);
			settle(8'h01);
		end
		check("dropCount", dropCount, 8'h12);
		$display("t_tree done");
	endtask
	task automatic t_all();
		setMask('1);
		@(posedge clk_sys);
		good <= '0;
		settle(8'h01);
		@(posedge clk_sys);
		good <= '1;
		setMask('0);
		settle(8'h01);
		$display("t_all done");
	endtask
	// Mid-run reset: rails mask returns to its reset value, pin low while held.
	task automatic t_rst();
		wrrd(PGTM_OFS_RAILS, 8'h3C, 8'h3C);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("pgOutputPinC", {7'h00, pgOutputPinC}, 8'h00);
		check("regRdData", regRdData, 8'h00);
		check("regRdValid", {7'h00, regRdValid}, 8'h00);
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(PGTM_OFS_RAILS, PGTM_RST_RAILS);
		settle(8'h01);
		$display("t_rst done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Free-running system clock.
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_tree();
		t_all();
		t_rst();
		final_report();
	end
	// Watchdog, several times the expected run of about 16 us.
	initial begin
		#100us;
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire

// file: logic/pgtm_mask_out3.sv
// Functional notes
// (RULE1) Rails bit 7 masks second adjustable LDO.
// (RULE2) Rails bit 6 masks load switch A one.
// (RULE3) Rails bits 5..0 mask step-down rails six..one.
// (RULE4) Aux bits 7..4 mask control pins 5,4,2,1.
// (RULE5) Aux bit 3 masks termination regulator.
// (RULE6) Aux bit 2 masks factory-chosen shared source.
// (RULE7) Aux bit 1 masks load switch B one.
// (RULE8) Aux bit 0 masks third adjustable LDO.
// (RULE9) Sleep register bits 1,0 mask pins 3,6.
// (RULE10) Output good when all unmasked sources good.
`timescale 1ns/1ps
`default_nettype none
module pgtm_mask_out3 #(
	parameter logic [7:0] RST_RAILS = pgtm_pkg::PGTM_RST_RAILS, // Rails reset.
	parameter logic [7:0] RST_PINS_AUX = pgtm_pkg::PGTM_RST_PINS_AUX, // Aux.
	parameter logic [7:0] RST_SLEEP = pgtm_pkg::PGTM_RST_SLEEP, // Sleep reset.
	parameter bit SHARED_USE_LDO = 1'b0 // 1: shared input is adjustable LDO one.
) (
	input wire logic clk_sys, // System clock, 40 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [7:0] regAddr, // Register offset.
	input wire logic [7:0] regWrData, // Write data.
	input wire logic regWrEn, // Write strobe, one cycle.
	input wire logic regRdEn, // Read strobe, one cycle.
	output logic [7:0] regRdData, // Read data, held until next read or reset.
	output logic regRdValid, // Read data valid, one-cycle pulse.
	input wire logic [5:0] stepDownPg, // Step-down rails six..one good.
	input wire logic adjLdoOnePg, // First adjustable LDO good.
	input wire logic adjLdoTwoPg, // Second adjustable LDO good.
	input wire logic adjLdoThreePg, // Third adjustable LDO good.
	input wire logic loadSwitchAOnePg, // Load switch A one good.
	input wire logic loadSwitchBOnePg, // Load switch B one good.
	input wire logic loadSwitchBTwoPg, // Load switch B two good.
	input wire logic terminationPg, // Termination regulator good.
	input wire logic [5:0] controlPin, // Control pins six..one levels.
	output logic pgOutputPinC // Aggregated power good, active high.
);
	import pgtm_pkg::*;

	// Synchroniser width: six rails, six pins and seven single sources.
	localparam int SYNC_W = 19;

	// Monitor inputs before and after the synchroniser, then unpacked.
	logic [SYNC_W-1:0] rawIn;
	logic [SYNC_W-1:0] syncIn;
	logic [5:0] stepDownS;
	logic [5:0] pinS;
	logic ldoOneS;
	logic ldoTwoS;
	logic ldoThreeS;
	logic swAOneS;
	logic swBOneS;
	logic swBTwoS;
	logic termS;
	logic sharedS;
	logic [PGTM_TREE_W-1:0] treeSrc;
	logic [PGTM_TREE_W-1:0] treeMask;

	// Mask registers, read port and output flop.
	logic [7:0] maskRails_r;
	logic [7:0] maskRails_nxt;
	logic [7:0] maskAux_r;
	logic [7:0] maskAux_nxt;
	logic [7:0] maskSleep_r;
	logic [7:0] maskSleep_nxt;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic rdValid_r;
	logic rdValid_nxt;
	logic pgOut_r;
	logic pgOut_nxt;

	// A source passes when it is good or its mask bit is set.
	function automatic logic treeGood(input logic [PGTM_TREE_W-1:0] src,
		input logic [PGTM_TREE_W-1:0] mask);
		treeGood = &(src | mask);
	endfunction

	// All monitor inputs come from analog comparators or pins.
	// Rails sit in bits 18:13, pins in 12:7, single sources below.
	assign rawIn = {
		stepDownPg,
		controlPin,
		adjLdoOnePg,
		adjLdoTwoPg,
		adjLdoThreePg,
		loadSwitchAOnePg,
		loadSwitchBOnePg,
		loadSwitchBTwoPg,
		terminationPg
	};

	// Both stages reset, so the tree reads bad until real levels arrive.
	pgtm_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.asyncIn(rawIn),
		.syncOut(syncIn)
	);

	// Unpack the synchronised levels.
	assign stepDownS = syncIn[18:13];
	assign pinS = syncIn[12:7];
	assign ldoOneS = syncIn[6];
	assign ldoTwoS = syncIn[5];
	assign ldoThreeS = syncIn[4];
	assign swAOneS = syncIn[3];
	assign swBOneS = syncIn[2];
	assign swBTwoS = syncIn[1];
	assign termS = syncIn[0];

	// The shared input is fixed at the factory, so a parameter is enough.
	assign sharedS = SHARED_USE_LDO ? ldoOneS : swBTwoS; // see (RULE6)

	// Sources line up bit for bit with the mask registers.
	assign treeSrc[17] = ldoTwoS; // see (RULE1)
	assign treeSrc[16] = swAOneS; // see (RULE2)
	assign treeSrc[15:10] = stepDownS; // see (RULE3)
	assign treeSrc[9] = pinS[4]; // see (RULE4)
	assign treeSrc[8] = pinS[3]; // see (RULE4)
	assign treeSrc[7] = pinS[1]; // see (RULE4)
	assign treeSrc[6] = pinS[0]; // see (RULE4)
	assign treeSrc[5] = termS; // see (RULE5)
	assign treeSrc[4] = sharedS; // see (RULE6)
	assign treeSrc[3] = swBOneS; // see (RULE7)
	assign treeSrc[2] = ldoThreeS; // see (RULE8)
	assign treeSrc[1] = pinS[2]; // see (RULE9)
	assign treeSrc[0] = pinS[5]; // see (RULE9)
	// Sleep masks fill the two lowest bits, pin three above pin six.
	assign treeMask = {maskRails_r, maskAux_r,
		maskSleep_r[PGTM_SLEEP_PIN_THREE], maskSleep_r[PGTM_SLEEP_PIN_SIX]};

	// Register writes; only the two owned sleep bits are stored.
	always_comb begin
		maskRails_nxt = maskRails_r;
		maskAux_nxt = maskAux_r;
		maskSleep_nxt = maskSleep_r;
		if (regWrEn) begin
			unique case (regAddr)
				PGTM_OFS_RAILS: begin
					maskRails_nxt = regWrData; // see (RULE1) (RULE2) (RULE3)
				end
				PGTM_OFS_PINS_AUX: begin
					maskAux_nxt = regWrData; // see (RULE4) (RULE5) (RULE8)
				end
				PGTM_OFS_SLEEP: begin
					maskSleep_nxt = regWrData & PGTM_SLEEP_OWNED; // see (RULE9)
				end
				default: begin
					// Writes to other offsets are dropped without effect.
					maskRails_nxt = maskRails_r;
				end
			endcase
		end
		if (reset) begin
			maskRails_nxt = RST_RAILS;
			maskAux_nxt = RST_PINS_AUX;
			maskSleep_nxt = RST_SLEEP & PGTM_SLEEP_OWNED;
		end
	end

	// Reads answer one cycle later; a same-cycle write is seen next read.
	// Unmapped offsets still answer, so a reader never waits forever.
	always_comb begin
		rdData_nxt = rdData_r;
		rdValid_nxt = 1'b0;
		if (regRdEn) begin
			rdValid_nxt = 1'b1;
			unique case (regAddr)
				PGTM_OFS_RAILS: begin
					rdData_nxt = maskRails_r;
				end
				PGTM_OFS_PINS_AUX: begin
					rdData_nxt = maskAux_r;
				end
				PGTM_OFS_SLEEP: begin
					rdData_nxt = maskSleep_r;
				end
				default: begin
					rdData_nxt = PGTM_RD_UNMAPPED;
				end
			endcase
		end
		if (reset) begin
			rdData_nxt = 8'h00;
			rdValid_nxt = 1'b0;
		end
	end

	// All-masked gives an empty AND, which reads as good.
	// Reset holds the pin low so the system never sees a false good.
	always_comb begin
		pgOut_nxt = treeGood(treeSrc, treeMask); // see (RULE10)
		if (reset) begin
			pgOut_nxt = 1'b0;
		end
	end

	// Mask registers.
	always_ff @(posedge clk_sys) begin
		maskRails_r <= maskRails_nxt;
		maskAux_r <= maskAux_nxt;
		maskSleep_r <= maskSleep_nxt;
	end

	// Read port registers.
	always_ff @(posedge clk_sys) begin
		rdData_r <= rdData_nxt;
		rdValid_r <= rdValid_nxt;
	end

	// Output flop; the pin comes straight from here.
	always_ff @(posedge clk_sys) begin
		pgOut_r <= pgOut_nxt;
	end

	assign regRdData = rdData_r;
	assign regRdValid = rdValid_r;
	assign pgOutputPinC = pgOut_r;
endmodule
`default_nettype wire

// file: logic/pgtm_pkg.sv
`default_nettype none
package pgtm_pkg;

	// Register offsets on the internal register port.
	localparam logic [7:0] PGTM_OFS_RAILS = 8'hAA;
	localparam logic [7:0] PGTM_OFS_PINS_AUX = 8'hAB;
	localparam logic [7:0] PGTM_OFS_SLEEP = 8'hAC;

	// Field positions in the rails mask register.
	localparam int PGTM_RAILS_ADJ_LDO_TWO = 7;
	localparam int PGTM_RAILS_LOAD_SW_A_ONE = 6;
	localparam int PGTM_RAILS_STEP_DOWN_HI = 5;
	localparam int PGTM_RAILS_STEP_DOWN_LO = 0;

	// Field positions in the pins and auxiliary mask register.
	localparam int PGTM_AUX_CTL_PIN_FIVE = 7;
	localparam int PGTM_AUX_CTL_PIN_FOUR = 6;
	localparam int PGTM_AUX_CTL_PIN_TWO = 5;
	localparam int PGTM_AUX_CTL_PIN_ONE = 4;
	localparam int PGTM_AUX_TERMINATION = 3;
	localparam int PGTM_AUX_SHARED_SOURCE = 2;
	localparam int PGTM_AUX_LOAD_SW_B_ONE = 1;
	localparam int PGTM_AUX_ADJ_LDO_THREE = 0;

	// Field positions in the sleep pin mask register.
	localparam int PGTM_SLEEP_PIN_THREE = 1;
	localparam int PGTM_SLEEP_PIN_SIX = 0;
	localparam logic [7:0] PGTM_SLEEP_OWNED = 8'h03;

	// Factory reset values; the real ones come from one-time memory.
	localparam logic [7:0] PGTM_RST_RAILS = 8'h00;
	localparam logic [7:0] PGTM_RST_PINS_AUX = 8'h00;
	localparam logic [7:0] PGTM_RST_SLEEP = 8'h00;

	// Answer to a read of any other offset.
	localparam logic [7:0] PGTM_RD_UNMAPPED = 8'h00;

	// Number of sources in the tree: two mask bytes and two sleep pins.
	localparam int PGTM_TREE_W = 18;

endpackage
`default_nettype wire

// file: logic/pgtm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a vector of unrelated level inputs.
module pgtm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] asyncIn, // Levels from outside the domain.
	output logic [WIDTH-1:0] syncOut // Levels safe to use on clk_sys.
);
	logic [WIDTH-1:0] stageOne_r;
	logic [WIDTH-1:0] stageOne_nxt;
	logic [WIDTH-1:0] stageTwo_r;
	logic [WIDTH-1:0] stageTwo_nxt;

	// The first stage feeds only the second, so metastability stays inside.
	always_comb begin
		stageOne_nxt = asyncIn;
		stageTwo_nxt = stageOne_r;
		if (reset) begin
			stageOne_nxt = '0;
			stageTwo_nxt = '0;
		end
	end

	// Plain registering of both stages.
	always_ff @(posedge clk_sys) begin
		stageOne_r <= stageOne_nxt;
		stageTwo_r <= stageTwo_nxt;
	end

	assign syncOut = stageTwo_r;
endmodule
`default_nettype wire
